// ### pkg/gpio_defines.svh
// Constants for the dual bidirectional port block
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

`define IO_ADDR_W 6
`define PORT_W 8

`define SECOND_PORT_PIN_SAMPLE_ADDR 6'h16
`define SECOND_PORT_DIRECTION_ADDR 6'h17
`define SECOND_PORT_OUTPUT_LATCH_ADDR 6'h18
`define FIRST_PORT_PIN_SAMPLE_ADDR 6'h19
`define FIRST_PORT_DIRECTION_ADDR 6'h1A
`define FIRST_PORT_OUTPUT_LATCH_ADDR 6'h1B

`define PORT_RESET_VALUE 8'h00
`define READ_UNMAPPED_VALUE 8'h00

`define BIT_TIMER_ZERO 0
`define BIT_TIMER_ONE 1
`define BIT_COMP_POS 2
`define BIT_COMP_NEG 3
`define BIT_SPI_SS 4
`define BIT_SPI_MOSI 5
`define BIT_SPI_MISO 6
`define BIT_SPI_SCK 7

`define SYNC_STAGES 2

`endif

// ### pkg/gpio_pkg.sv
// Types shared by the port block
`default_nettype none
package gpio_pkg;
  typedef logic [7:0] port_byte_t;
  typedef logic [5:0] io_addr_t;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_A_LATCH = 3'b001,
    SEL_A_DIR = 3'b010,
    SEL_A_PIN = 3'b011,
    SEL_B_LATCH = 3'b100,
    SEL_B_DIR = 3'b101,
    SEL_B_PIN = 3'b110
  } reg_sel_t;
endpackage : gpio_pkg
`default_nettype wire

// ### pkg/port_ctrl_if.sv
// Control and sample signals between register logic and one port
`timescale 1ns/100ps
`default_nettype none
interface port_ctrl_if;
  import gpio_pkg::*;
  port_byte_t dir;
  port_byte_t latch;
  logic pullup_disable;
  port_byte_t force_input;
  port_byte_t alt_drive;
  port_byte_t alt_value;
  port_byte_t sample;
  modport ctrl (output dir, output latch, output pullup_disable, output force_input,
    output alt_drive, output alt_value, input sample);
  modport pad (input dir, input latch, input pullup_disable, input force_input,
    input alt_drive, input alt_value, output sample);
endinterface : port_ctrl_if
`default_nettype wire

// ### hdl/port_pads.sv
// Pad control and pin synchronizer for one 8-bit port
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
module port_pads
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register side
  port_ctrl_if.pad ctrl,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup
);
  port_byte_t sync_first;
  port_byte_t sync_second;

  // Two-stage synchronizer
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_first <= `PORT_RESET_VALUE;
      sync_second <= `PORT_RESET_VALUE;
    end else begin
      sync_first <= pin_in;
      sync_second <= sync_first;
    end
  end

  assign ctrl.sample = sync_second;

  genvar n;
  generate
    for (n = 0; n < `PORT_W; n++) begin : g_pin
      logic is_output;
      assign is_output = ctrl.dir[n] & ~ctrl.force_input[n];
      // Reset gates the driver without waiting for a clock
      assign pin_oe[n] = is_output & ~reset;
      assign pin_out[n] = ctrl.alt_drive[n] ? ctrl.alt_value[n] : ctrl.latch[n];
      assign pin_pullup[n] = ~is_output & ctrl.latch[n] & ~ctrl.pullup_disable & ~reset;
    end
  endgenerate
endmodule : port_pads
`default_nettype wire

// ### hdl/dual_port_gpio.sv
// Two 8-bit bidirectional ports with I/O register access and SPI pin override
`timescale 1ns/100ps
`default_nettype none
`include "gpio_defines.svh"
module dual_port_gpio
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // I/O register access
  input wire logic [5:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  // Global settings
  input wire logic GLOBAL_PULLUP_DISABLE,
  // SPI control and data
  input wire logic SPI_ENABLE,
  input wire logic SPI_MASTER,
  input wire logic SPI_SCK_OUT,
  input wire logic SPI_MOSI_OUT,
  input wire logic SPI_MISO_OUT,
  output logic SPI_SCK_IN,
  output logic SPI_MOSI_IN,
  output logic SPI_MISO_IN,
  output logic SPI_SS_IN,
  output logic SPI_SLAVE_ACTIVE,
  // Other alternate inputs
  output logic TIMER_ZERO_COUNT_IN,
  output logic TIMER_ONE_COUNT_IN,
  output logic COMPARATOR_POS_IN,
  output logic COMPARATOR_NEG_IN,
  // First port pins
  input wire logic [7:0] FIRST_PORT_PIN_IN,
  output logic [7:0] FIRST_PORT_PIN_OUT,
  output logic [7:0] FIRST_PORT_PIN_OE,
  output logic [7:0] FIRST_PORT_PULLUP,
  // Second port pins
  input wire logic [7:0] SECOND_PORT_PIN_IN,
  output logic [7:0] SECOND_PORT_PIN_OUT,
  output logic [7:0] SECOND_PORT_PIN_OE,
  output logic [7:0] SECOND_PORT_PULLUP
);
  port_ctrl_if first_ctrl ();
  port_ctrl_if second_ctrl ();

  port_byte_t first_port_output_latch;
  port_byte_t first_port_direction;
  port_byte_t second_port_output_latch;
  port_byte_t second_port_direction;
  port_byte_t first_port_pin_sample;
  port_byte_t second_port_pin_sample;
  port_byte_t next_rdata;
  reg_sel_t sel;
  logic spi_slave_mode;
  logic spi_master_mode;
  port_byte_t second_force;
  port_byte_t second_alt_drive;
  port_byte_t second_alt_value;

  // Address decode
  always_comb begin
    case (IO_ADDR)
      `FIRST_PORT_OUTPUT_LATCH_ADDR: sel = SEL_A_LATCH;
      `FIRST_PORT_DIRECTION_ADDR: sel = SEL_A_DIR;
      `FIRST_PORT_PIN_SAMPLE_ADDR: sel = SEL_A_PIN;
      `SECOND_PORT_OUTPUT_LATCH_ADDR: sel = SEL_B_LATCH;
      `SECOND_PORT_DIRECTION_ADDR: sel = SEL_B_DIR;
      `SECOND_PORT_PIN_SAMPLE_ADDR: sel = SEL_B_PIN;
      default: sel = SEL_NONE;
    endcase
  end

  // First port registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      first_port_output_latch <= `PORT_RESET_VALUE;
      first_port_direction <= `PORT_RESET_VALUE;
    end else if (IO_WR) begin
      if (sel == SEL_A_LATCH) begin
        first_port_output_latch <= IO_WDATA;
      end
      if (sel == SEL_A_DIR) begin
        first_port_direction <= IO_WDATA;
      end
    end
  end

  // Second port registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      second_port_output_latch <= `PORT_RESET_VALUE;
      second_port_direction <= `PORT_RESET_VALUE;
    end else if (IO_WR) begin
      if (sel == SEL_B_LATCH) begin
        second_port_output_latch <= IO_WDATA;
      end
      if (sel == SEL_B_DIR) begin
        second_port_direction <= IO_WDATA;
      end
    end
  end

  // Read multiplexer; pin-sample addresses ignore writes
  always_comb begin
    case (sel)
      SEL_A_LATCH: next_rdata = first_port_output_latch;
      SEL_A_DIR: next_rdata = first_port_direction;
      SEL_A_PIN: next_rdata = first_port_pin_sample;
      SEL_B_LATCH: next_rdata = second_port_output_latch;
      SEL_B_DIR: next_rdata = second_port_direction;
      SEL_B_PIN: next_rdata = second_port_pin_sample;
      default: next_rdata = `READ_UNMAPPED_VALUE;
    endcase
  end

  // Read data register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      IO_RDATA <= `READ_UNMAPPED_VALUE;
    end else if (IO_RD) begin
      IO_RDATA <= next_rdata;
    end
  end

  // SPI mode decode
  assign spi_slave_mode = SPI_ENABLE & ~SPI_MASTER;
  assign spi_master_mode = SPI_ENABLE & SPI_MASTER;

  // Direction override on the second port
  always_comb begin
    second_force = 8'h00;
    second_force[`BIT_SPI_SCK] = spi_slave_mode;
    second_force[`BIT_SPI_MISO] = spi_master_mode;
    second_force[`BIT_SPI_MOSI] = spi_slave_mode;
    second_force[`BIT_SPI_SS] = spi_slave_mode;
  end

  // SPI drives its output pins when their direction allows
  always_comb begin
    second_alt_drive = 8'h00;
    second_alt_value = 8'h00;
    second_alt_drive[`BIT_SPI_SCK] = spi_master_mode;
    second_alt_value[`BIT_SPI_SCK] = SPI_SCK_OUT;
    second_alt_drive[`BIT_SPI_MOSI] = spi_master_mode;
    second_alt_value[`BIT_SPI_MOSI] = SPI_MOSI_OUT;
    second_alt_drive[`BIT_SPI_MISO] = spi_slave_mode;
    second_alt_value[`BIT_SPI_MISO] = SPI_MISO_OUT;
  end

  // First port control
  assign first_ctrl.dir = first_port_direction;
  assign first_ctrl.latch = first_port_output_latch;
  assign first_ctrl.pullup_disable = GLOBAL_PULLUP_DISABLE;
  assign first_ctrl.force_input = 8'h00;
  assign first_ctrl.alt_drive = 8'h00;
  assign first_ctrl.alt_value = 8'h00;
  assign first_port_pin_sample = first_ctrl.sample;

  // Second port control
  assign second_ctrl.dir = second_port_direction;
  assign second_ctrl.latch = second_port_output_latch;
  assign second_ctrl.pullup_disable = GLOBAL_PULLUP_DISABLE;
  assign second_ctrl.force_input = second_force;
  assign second_ctrl.alt_drive = second_alt_drive;
  assign second_ctrl.alt_value = second_alt_value;
  assign second_port_pin_sample = second_ctrl.sample;

  port_pads u_first_pads (
    .clk(CLK),
    .reset(RESET),
    .ctrl(first_ctrl.pad),
    .pin_in(FIRST_PORT_PIN_IN),
    .pin_out(FIRST_PORT_PIN_OUT),
    .pin_oe(FIRST_PORT_PIN_OE),
    .pin_pullup(FIRST_PORT_PULLUP)
  );

  port_pads u_second_pads (
    .clk(CLK),
    .reset(RESET),
    .ctrl(second_ctrl.pad),
    .pin_in(SECOND_PORT_PIN_IN),
    .pin_out(SECOND_PORT_PIN_OUT),
    .pin_oe(SECOND_PORT_PIN_OE),
    .pin_pullup(SECOND_PORT_PULLUP)
  );

  // Alternate function inputs from synchronized pins
  assign TIMER_ZERO_COUNT_IN = second_port_pin_sample[`BIT_TIMER_ZERO];
  assign TIMER_ONE_COUNT_IN = second_port_pin_sample[`BIT_TIMER_ONE];
  assign COMPARATOR_POS_IN = second_port_pin_sample[`BIT_COMP_POS];
  assign COMPARATOR_NEG_IN = second_port_pin_sample[`BIT_COMP_NEG];
  assign SPI_SS_IN = second_port_pin_sample[`BIT_SPI_SS];
  assign SPI_MOSI_IN = second_port_pin_sample[`BIT_SPI_MOSI];
  assign SPI_MISO_IN = second_port_pin_sample[`BIT_SPI_MISO];
  assign SPI_SCK_IN = second_port_pin_sample[`BIT_SPI_SCK];

  // Slave active only while select is low
  assign SPI_SLAVE_ACTIVE = spi_slave_mode & ~second_port_pin_sample[`BIT_SPI_SS];
endmodule : dual_port_gpio
`default_nettype wire

// ### sim/gpio_checker.sv
// Concurrent checks on the dual port block
`timescale 1ns/100ps
`default_nettype none
module gpio_checker
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register access
  input wire logic [5:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  // Settings and SPI
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic SPI_ENABLE,
  input wire logic SPI_MASTER,
  input wire logic SPI_SS_IN,
  input wire logic SPI_SLAVE_ACTIVE,
  // Pins
  input wire logic [7:0] FIRST_PORT_PIN_IN,
  input wire logic [7:0] FIRST_PORT_PIN_OUT,
  input wire logic [7:0] FIRST_PORT_PIN_OE,
  input wire logic [7:0] FIRST_PORT_PULLUP,
  input wire logic [7:0] SECOND_PORT_PIN_OE,
  input wire logic [7:0] SECOND_PORT_PULLUP
);
  default clocking cb @(posedge CLK);
  endclocking
  a_reset_tristate: assert property (
    RESET |-> (FIRST_PORT_PIN_OE | SECOND_PORT_PIN_OE | FIRST_PORT_PULLUP | SECOND_PORT_PULLUP) == 8'h00)
    else $error("pins active in reset");
  a_dir_write: assert property (
    disable iff (RESET) IO_WR && IO_ADDR == 6'h1A |=> FIRST_PORT_PIN_OE == $past(IO_WDATA))
    else $error("direction not applied");
  a_latch_drive: assert property (
    disable iff (RESET) IO_WR && IO_ADDR == 6'h1B |=>
    ((FIRST_PORT_PIN_OUT ^ $past(IO_WDATA)) & FIRST_PORT_PIN_OE) == 8'h00)
    else $error("output level wrong");
  a_pullup_set: assert property (
    disable iff (RESET) IO_WR && IO_ADDR == 6'h1B |=>
    FIRST_PORT_PULLUP == ($past(IO_WDATA) & ~FIRST_PORT_PIN_OE & {8{!GLOBAL_PULLUP_DISABLE}}))
    else $error("pull-up wrong");
  a_pullup_off: assert property (
    disable iff (RESET) (FIRST_PORT_PULLUP & (FIRST_PORT_PIN_OE | {8{GLOBAL_PULLUP_DISABLE}})) == 8'h00)
    else $error("pull-up not off");
  a_slave_force: assert property (
    disable iff (RESET) SPI_ENABLE && !SPI_MASTER |-> (SECOND_PORT_PIN_OE & 8'hB0) == 8'h00)
    else $error("slave pins driven");
  a_master_force: assert property (
    disable iff (RESET) SPI_ENABLE && SPI_MASTER |-> !SECOND_PORT_PIN_OE[6])
    else $error("master input driven");
  a_pin_latency: assert property (
    disable iff (RESET) IO_RD && IO_ADDR == 6'h19 |=> IO_RDATA == $past(FIRST_PORT_PIN_IN, 3))
    else $error("pin sample latency wrong");
  a_slave_select: assert property (
    disable iff (RESET) SPI_SLAVE_ACTIVE == (SPI_ENABLE && !SPI_MASTER && !SPI_SS_IN))
    else $error("slave active wrong");
endmodule : gpio_checker
bind dual_port_gpio gpio_checker i_gpio_checker(.CLK, .RESET, .IO_ADDR, .IO_WR, .IO_RD, .IO_WDATA,
  .IO_RDATA, .GLOBAL_PULLUP_DISABLE, .SPI_ENABLE, .SPI_MASTER, .SPI_SS_IN, .SPI_SLAVE_ACTIVE,
  .FIRST_PORT_PIN_IN, .FIRST_PORT_PIN_OUT, .FIRST_PORT_PIN_OE, .FIRST_PORT_PULLUP,
  .SECOND_PORT_PIN_OE, .SECOND_PORT_PULLUP);
`default_nettype wire

// ### sim/pin_world.sv
// Board side of one port: drivers, pull-ups and floating lines
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] pull_en,
  // Board drivers
  input wire logic [7:0] drive,
  input wire logic [7:0] value,
  output logic [7:0] level
);
  logic [7:0] noise = 8'h55;
  // Floating lines wander
  always @(posedge clk) noise <= ~noise;
  // Device drive, board drive, pull-up, else float
  assign level = (oe & out) | (~oe & drive & value) | (~oe & ~drive & pull_en)
    | (~oe & ~drive & ~pull_en & noise);
endmodule : pin_world
`default_nettype wire

// ### sim/test_dual_port_gpio.sv
// Register level testbench of the dual port block
`timescale 1ns/100ps
`default_nettype none
module test_dual_port_gpio
  import gpio_pkg::*;
;
  logic clk, reset, wr_s, rd_s, gpd, spi_en, spi_ms;
  logic [5:0] addr, base;
  logic [7:0] wdata, rdata, oe_a, out_a, pu_a, oe_b, out_b, pu_b, lv_a, lv_b, drv, val;
  logic sck, mosi, miso, ss, act, t0, t1, cp, cn;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  dual_port_gpio i_dual_port_gpio(.CLK(clk), .RESET(reset), .IO_ADDR(addr), .IO_WR(wr_s), .IO_RD(rd_s),
    .IO_WDATA(wdata), .IO_RDATA(rdata), .GLOBAL_PULLUP_DISABLE(gpd), .SPI_ENABLE(spi_en),
    .SPI_MASTER(spi_ms), .SPI_SCK_OUT(1'b0), .SPI_MOSI_OUT(1'b1), .SPI_MISO_OUT(1'b0),
    .SPI_SCK_IN(sck), .SPI_MOSI_IN(mosi), .SPI_MISO_IN(miso), .SPI_SS_IN(ss), .SPI_SLAVE_ACTIVE(act),
    .TIMER_ZERO_COUNT_IN(t0), .TIMER_ONE_COUNT_IN(t1), .COMPARATOR_POS_IN(cp), .COMPARATOR_NEG_IN(cn),
    .FIRST_PORT_PIN_IN(lv_a), .FIRST_PORT_PIN_OUT(out_a), .FIRST_PORT_PIN_OE(oe_a), .FIRST_PORT_PULLUP(pu_a),
    .SECOND_PORT_PIN_IN(lv_b), .SECOND_PORT_PIN_OUT(out_b), .SECOND_PORT_PIN_OE(oe_b),
    .SECOND_PORT_PULLUP(pu_b));
  pin_world i_pin_world_a(.clk(clk), .oe(oe_a), .out(out_a), .pull_en(pu_a), .drive(drv), .value(val),
    .level(lv_a));
  pin_world i_pin_world_b(.clk(clk), .oe(oe_b), .out(out_b), .pull_en(pu_b), .drive(drv), .value(val),
    .level(lv_b));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    {reset, wr_s, rd_s, gpd, spi_en, spi_ms} = 6'h20;
    {addr, wdata, drv, val} = '0;
    #1 chk(oe_a | oe_b | pu_a | pu_b, 8'h00);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(6'h17, 8'h00);
    rd(6'h18, 8'h00);
    rd(6'h1A, 8'h00);
    rd(6'h1B, 8'h00);
    rd(6'h20, 8'h00);
    $display("reset test done");
    drv <= 8'hF0;
    val <= 8'h3C;
    for (int p = 0; p < 2; p++) begin
      base = p ? 6'h16 : 6'h19;
      wr(base + 6'h2, 8'hA5);
      wr(base + 6'h1, 8'h0F);
      wr(base, 8'hFF);
      rd(base + 6'h2, 8'hA5);
      rd(base + 6'h1, 8'h0F);
      chk(p ? oe_b : oe_a, 8'h0F);
      chk((p ? out_b : out_a) & 8'h0F, 8'h05);
      chk(p ? pu_b : pu_a, 8'hA0);
      @(posedge clk);
      gpd <= 1'b1;
      #1 chk(p ? pu_b : pu_a, 8'h00);
      @(posedge clk);
      gpd <= 1'b0;
      rd(base, 8'h35);
    end
    chk({sck, miso, mosi, ss, cn, cp, t1, t0}, 8'h35);
    @(posedge clk);
    val <= 8'hC3;
    rd(6'h16, 8'h35);
    rd(6'h16, 8'hC5);
    @(posedge clk);
    val <= 8'h3C;
    @(posedge clk);
    rd(6'h16, 8'h35);
    $display("port test done");
    wr(6'h17, 8'hFF);
    wr(6'h18, 8'hF0);
    @(posedge clk);
    spi_en <= 1'b1;
    drv <= 8'h10;
    val <= 8'h00;
    #1 chk(oe_b, 8'h4F);
    chk(pu_b, 8'hB0);
    repeat (3) @(posedge clk);
    val <= 8'h10;
    #1 chk({7'h00, act}, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, act}, 8'h00);
    @(posedge clk);
    spi_ms <= 1'b1;
    drv <= 8'h00;
    #1 chk({7'h00, act}, 8'h00);
    chk(oe_b, 8'hBF);
    chk(pu_b, 8'h40);
    $display("spi test done");
    @(posedge clk);
    reset <= 1'b1;
    #1 chk(oe_a | oe_b | pu_a | pu_b, 8'h00);
    @(posedge clk);
    reset <= 1'b0;
    rd(6'h17, 8'h00);
    $display("mid reset test done");
    final_report;
  end
endmodule : test_dual_port_gpio
`default_nettype wire
